// [nfc_receive_packet_fifo_crc.sv]
// receive packet path: shared byte queue, length window, auto polling answer, checksum
`timescale 1ns/1ps
`default_nettype none
`include "pktq_regs.svh"
module nfc_receive_packet_fifo_crc import pktq_pkg::*; #(
    parameter int DEPTH = 64,          // queue entries
    parameter int RESP_BYTES = 20,     // polling answer store
    parameter int SLOT_CYCLES = `SLOT_CYCLES_DEF // cycles per timeslot
) (
    input wire logic CORE_CLK,         // 25 MHz core clock
    input wire logic SRST,             // synchronous reset
    input wire logic [5:0] ADDR,       // register index
    input wire logic [7:0] WDATA,      // write data
    input wire logic WR,               // write strobe
    input wire logic RD,               // read strobe
    output logic [7:0] RDATA,          // read data, cycle after RD
    input wire logic RX_VALID,         // decoded byte pulse
    input wire logic [7:0] RX_BYTE,    // decoded byte
    input wire logic RX_END,           // end of packet pulse
    input wire logic [3:0] RX_ERR,     // packet errors, valid with RX_END
    output logic TX_VALID,             // answer byte valid
    output logic [7:0] TX_BYTE,        // answer byte
    output logic TX_LAST,              // last answer byte
    input wire logic TX_READY,         // encoder takes byte
    output logic AUTO_ACTIVE           // auto polling running
);
    localparam int AW = $clog2(DEPTH);
    localparam int RW = $clog2(RESP_BYTES);

    logic [7:0] mem [DEPTH];
    logic [7:0] resp [RESP_BYTES];
    logic [AW:0] wr_q, rd_q, pkt_start_q;
    logic [AW:0] level;
    logic full, empty;
    logic ovf_q;
    logic [3:0] err_q;
    logic [7:0] mode_q, rxmode_q, lenlo_q, lenhi_q, rdata_q;
    logic [RW-1:0] raddr_q;
    logic auto_q, rx_on_q;
    rx_state_e rx_q;
    tx_state_e tx_q;
    logic [2:0] idx_q;
    logic [7:0] cmd_q, sch_q, scl_q, tsn_q, lfsr_q, slot_q, txi_q;
    logic [15:0] slot_cnt_q;
    logic [15:0] crc;
    logic [8:0] len_min, len_max;
    logic len_ok, poll_end, match, valid_end;
    logic wr_host, rd_host, flush, rx_wr, q_wr, drop_wr;
    logic [7:0] q_wdata;

    // register strobes decoded from the index
    assign wr_host = WR && ADDR == `OFS_QUEUE_DATA;
    assign rd_host = RD && ADDR == `OFS_QUEUE_DATA;
    assign flush = WR && ADDR == `OFS_QUEUE_LEVEL && WDATA[`BIT_FLUSH];

    assign level = wr_q - rd_q;
    assign full = level == (AW + 1)'(DEPTH);
    assign empty = level == '0;

    // lower bound four bytes per step
    // upper bound, zero field means 256
    assign len_min = {1'b0, lenlo_q[5:0], 2'b00};
    assign len_max = lenhi_q[5:0] == 6'd0 ? `LEN_MAX_DEFAULT : {1'b0, lenhi_q[5:0], 2'b00};
    assign len_ok = {1'b0, RX_BYTE} >= len_min && {1'b0, RX_BYTE} < len_max;

    // FF in the received code is a wildcard
    assign match = (sch_q == `SYSCODE_WILD || sch_q == resp[`SYSCODE_POS_HI])
                && (scl_q == `SYSCODE_WILD || scl_q == resp[`SYSCODE_POS_LO]);
    assign valid_end = rx_q == RX_DATA && RX_END && RX_ERR == 4'h0;
    assign poll_end = valid_end && auto_q && cmd_q == `POLL_CMD_CODE;

    // receiver owns the write port; host writes in the same cycle lose
    assign rx_wr = (rx_q == RX_DATA && (RX_VALID || RX_END)) || (rx_q == RX_IDLE && RX_VALID
                   && rx_on_q && len_ok);
    assign q_wr = rx_wr || wr_host;
    assign drop_wr = q_wr && full;
    // status byte written on packet end
    assign q_wdata = !rx_wr ? WDATA : (rx_q == RX_DATA && RX_END) ? {3'b000, ovf_q, RX_ERR}
                     : RX_BYTE;

    // queue storage; full queue discards the byte
    always_ff @(posedge CORE_CLK) begin
        if (q_wr && !full) begin
            mem[wr_q[AW-1:0]] <= q_wdata;
        end
    end

    // flush resets pointers
    // error-free polling packets taken while auto polling runs are rolled back so they never reach software
    always_ff @(posedge CORE_CLK) begin
        if (SRST || flush) begin
            wr_q <= '0;
        end else if (poll_end) begin
            wr_q <= pkt_start_q;
        end else if (q_wr && !full) begin
            wr_q <= wr_q + 1'b1;
        end
    end

    // read returns current entry then moves on
    always_ff @(posedge CORE_CLK) begin
        if (SRST || flush) begin
            rd_q <= '0;
        end else if (rd_host && !empty) begin
            rd_q <= rd_q + 1'b1;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            ovf_q <= 1'b0;
        end else if (drop_wr) begin
            ovf_q <= 1'b1;
        end else if (flush) begin
            ovf_q <= 1'b0;
        end
    end

    // packet error flags latched per accepted packet
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            err_q <= 4'h0;
        end else if (rx_q == RX_DATA && RX_END) begin
            err_q <= RX_ERR;
        end
    end

    // configuration registers
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            mode_q <= `RST_GEN_MODE;
            lenlo_q <= `RST_LEN_LOW;
            lenhi_q <= `RST_LEN_HIGH;
            raddr_q <= '0;
        end else if (WR) begin
            case (ADDR)
                `OFS_GEN_MODE: mode_q <= WDATA;
                `OFS_LEN_LOW: lenlo_q <= WDATA;
                `OFS_LEN_HIGH: lenhi_q <= WDATA;
                `OFS_RESP_ADDR: raddr_q <= WDATA[RW-1:0];
                `OFS_RESP_DATA: raddr_q <= raddr_q + 1'b1;
                default: ;
            endcase
        end
    end

    // answer bytes loaded by the host, address auto-increments
    always_ff @(posedge CORE_CLK) begin
        if (WR && ADDR == `OFS_RESP_DATA) begin
            resp[raddr_q] <= WDATA;
        end
    end

    // receiver stays armed in continuous mode
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            rxmode_q <= `RST_RX_MODE;
            rx_on_q <= 1'b0;
        end else if (WR && ADDR == `OFS_RX_MODE) begin
            rxmode_q <= WDATA;
            rx_on_q <= WDATA[`BIT_RX_ENABLE];
        end else if (WR && ADDR == `OFS_COMMAND && WDATA[3:0] == `CMD_AUTO_ANTICOL) begin
            rx_on_q <= 1'b1;
        end else if (rx_q == RX_DATA && RX_END && !rxmode_q[`BIT_RX_CONT] && !poll_end) begin
            rx_on_q <= 1'b0;
        end
    end

    // rejected length drops the packet yet keeps listening
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            rx_q <= RX_IDLE;
        end else begin
            case (rx_q)
                RX_IDLE: if (RX_VALID && rx_on_q) begin
                    rx_q <= len_ok ? RX_DATA : RX_DROP;
                end
                RX_DATA: if (RX_END) begin
                    rx_q <= RX_IDLE;
                end
                RX_DROP: if (RX_END) begin
                    rx_q <= RX_IDLE;
                end
                default: rx_q <= RX_IDLE;
            endcase
        end
    end

    // capture command fields: code, code hi, code lo and slot limit; length and request bytes are skipped
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            idx_q <= 3'd0;
            cmd_q <= 8'h00;
            sch_q <= 8'h00;
            scl_q <= 8'h00;
            tsn_q <= 8'h00;
            pkt_start_q <= '0;
        end else if (rx_q == RX_IDLE && RX_VALID) begin
            idx_q <= 3'd1;
            pkt_start_q <= wr_q;
        end else if (rx_q == RX_DATA && RX_VALID) begin
            idx_q <= idx_q == 3'd7 ? idx_q : idx_q + 1'b1;
            case (idx_q)
                3'd1: cmd_q <= RX_BYTE;
                3'd2: sch_q <= RX_BYTE;
                3'd3: scl_q <= RX_BYTE;
                3'd5: tsn_q <= RX_BYTE;
                default: ;
            endcase
        end
    end

    // auto polling only via the command
    // a valid other command ends it
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            auto_q <= 1'b0;
        end else if (WR && ADDR == `OFS_COMMAND) begin
            auto_q <= WDATA[3:0] == `CMD_AUTO_ANTICOL;
        end else if (valid_end && auto_q && cmd_q != `POLL_CMD_CODE) begin
            auto_q <= 1'b0;
        end
    end
    assign AUTO_ACTIVE = auto_q;

    // free-running pseudo-random source for slot choice
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            lfsr_q <= 8'hA5;
        end else begin
            lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
        end
    end

    // no answer without a code match
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            tx_q <= TX_IDLE;
            slot_q <= 8'h00;
            slot_cnt_q <= 16'h0000;
            txi_q <= 8'h00;
        end else begin
            case (tx_q)
                TX_IDLE: if (poll_end && match) begin
                    tx_q <= TX_WAIT;
                    slot_q <= 8'((9'(lfsr_q)) % (9'(tsn_q) + 9'd1));
                    slot_cnt_q <= 16'h0000;
                    txi_q <= 8'h00;
                end
                TX_WAIT: if (slot_q == 8'h00) begin
                    tx_q <= TX_SEND;
                end else if (slot_cnt_q == 16'(SLOT_CYCLES - 1)) begin
                    slot_cnt_q <= 16'h0000;
                    slot_q <= slot_q - 1'b1;
                end else begin
                    slot_cnt_q <= slot_cnt_q + 1'b1;
                end
                TX_SEND: if (TX_READY) begin
                    txi_q <= txi_q + 1'b1;
                    if (TX_LAST) begin
                        tx_q <= TX_IDLE;
                    end
                end
                default: tx_q <= TX_IDLE;
            endcase
        end
    end

    // answer length comes from its own length byte, clipped to the store
    assign TX_VALID = tx_q == TX_SEND;
    assign TX_BYTE = resp[RW'(txi_q)];
    assign TX_LAST = txi_q + 8'd1 >= resp[0] || txi_q == 8'(RESP_BYTES - 1);

    // checksum engine: mode write reloads the preset, data writes feed it
    checksum_unit u_crc (
        .clk(CORE_CLK),
        .rst(SRST),
        .preset_sel(WR && ADDR == `OFS_GEN_MODE ? WDATA[1:0] : mode_q[1:0]),
        .msb_first(mode_q[`BIT_CRC_MSB]),
        .load(WR && ADDR == `OFS_GEN_MODE),
        .feed(WR && ADDR == `OFS_CRC_DATA),
        .din(WDATA),
        .crc(crc)
    );

    // read data registered; only valid the cycle after RD
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            rdata_q <= 8'h00;
        end else if (RD) begin
            case (ADDR)
                `OFS_COMMAND: rdata_q <= {4'h0, auto_q ? `CMD_AUTO_ANTICOL : `CMD_IDLE};
                `OFS_GEN_MODE: rdata_q <= mode_q;
                `OFS_RX_MODE: rdata_q <= rxmode_q;
                `OFS_ERR_FLAGS: rdata_q <= {3'b000, ovf_q, err_q};
                `OFS_QUEUE_DATA: rdata_q <= mem[rd_q[AW-1:0]];
                `OFS_QUEUE_LEVEL: rdata_q <= 8'(level);
                `OFS_LEN_LOW: rdata_q <= lenlo_q;
                `OFS_LEN_HIGH: rdata_q <= lenhi_q;
                `OFS_CRC_HI: rdata_q <= crc[15:8];
                `OFS_CRC_LO: rdata_q <= crc[7:0];
                default: rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end
    assign RDATA = rdata_q;

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (SRST);

    sequence s_poll_seen;
        poll_end && tx_q == TX_IDLE;
    endsequence

    a_flush_clears: assert property (flush && !drop_wr |=> level == '0 && !ovf_q)
        else $error("flush left data or overflow");
    a_overflow_set: assert property (drop_wr |=> ovf_q && wr_q == $past(wr_q))
        else $error("overflow not flagged");
    a_host_write: assert property (wr_host && !rx_wr && !full && !flush && !poll_end && !rd_host
        |=> level == $past(level) + 1'b1)
        else $error("host write did not advance");
    a_host_read: assert property (rd_host && !empty && !q_wr && !flush && !poll_end
        |=> level == $past(level) - 1'b1 ##0 RDATA == $past(mem[rd_q[AW-1:0]]))
        else $error("host read wrong");
    a_len_reject: assert property (rx_q == RX_IDLE && RX_VALID && rx_on_q && !len_ok
        |=> rx_q == RX_DROP && wr_q == $past(wr_q))
        else $error("rejected length stored");
    a_status_byte: assert property (rx_q == RX_DATA && RX_END && !full && !poll_end && !flush
        |=> mem[$past(wr_q[AW-1:0])] == {3'b000, $past(ovf_q), $past(RX_ERR)})
        else $error("status byte missing");
    a_slot_range: assert property (s_poll_seen ##0 match |=> tx_q == TX_WAIT && slot_q <= tsn_q)
        else $error("slot out of range");
    a_no_answer: assert property (s_poll_seen ##0 !match |=> tx_q == TX_IDLE [*2])
        else $error("answer despite mismatch");
    a_auto_only: assert property (tx_q == TX_IDLE && !auto_q |=> tx_q == TX_IDLE)
        else $error("answer without auto command");
    a_other_stops: assert property (valid_end && auto_q && cmd_q != `POLL_CMD_CODE && !WR
        |=> !auto_q && tx_q == $past(tx_q))
        else $error("other command did not stop auto");
endmodule
`default_nettype wire

// [pktq_regs.svh]
// register offsets, field positions, reset values and counts of the packet queue block
`ifndef PKTQ_REGS_SVH
`define PKTQ_REGS_SVH

`define OFS_COMMAND      6'h00
`define OFS_GEN_MODE     6'h01
`define OFS_RX_MODE      6'h02
`define OFS_ERR_FLAGS    6'h03
`define OFS_QUEUE_DATA   6'h04
`define OFS_QUEUE_LEVEL  6'h05
`define OFS_LEN_LOW      6'h06
`define OFS_LEN_HIGH     6'h07
`define OFS_CRC_HI       6'h08
`define OFS_CRC_LO       6'h09
`define OFS_CRC_DATA     6'h0A
`define OFS_RESP_ADDR    6'h0B
`define OFS_RESP_DATA    6'h0C

`define CMD_IDLE         4'h0
`define CMD_AUTO_ANTICOL 4'hD

`define BIT_RX_ENABLE    0
`define BIT_RX_CONT      2
`define BIT_CRC_MSB      3
`define BIT_OVERFLOW     4
`define BIT_FLUSH        7

`define RST_GEN_MODE     8'h00
`define RST_RX_MODE      8'h00
`define RST_LEN_LOW      8'h00
`define RST_LEN_HIGH     8'h00

`define CRC_PRESET_0     16'h0000
`define CRC_PRESET_1     16'h6363
`define CRC_PRESET_2     16'hA671
`define CRC_PRESET_3     16'hFFFF
`define CRC_POLY_MSB     16'h1021
`define CRC_POLY_LSB     16'h8408

`define POLL_CMD_CODE    8'h00
`define SYSCODE_WILD     8'hFF
`define SYSCODE_POS_HI   5'd17
`define SYSCODE_POS_LO   5'd18
`define LEN_UNIT_SHIFT   2
`define LEN_MAX_DEFAULT  9'h100
`define SLOT_CYCLES_DEF  32'd64

`endif

// [pktq_pkg.sv]
// types shared by the packet queue block
package pktq_pkg;
    typedef enum logic [1:0] {RX_IDLE, RX_DATA, RX_DROP} rx_state_e;
    typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_SEND} tx_state_e;
endpackage

// [checksum_unit.sv]
// 16-bit checksum engine with selectable preset and bit order
`timescale 1ns/1ps
`default_nettype none
`include "pktq_regs.svh"
module checksum_unit import pktq_pkg::*; (
    input wire logic clk,             // core clock
    input wire logic rst,             // synchronous reset
    input wire logic [1:0] preset_sel, // preset choice
    input wire logic msb_first,       // high bit leading
    input wire logic load,            // reload preset
    input wire logic feed,            // one data byte
    input wire logic [7:0] din,       // data byte
    output logic [15:0] crc           // running result
);
    logic [15:0] crc_q;
    logic [15:0] preset;

    // one byte of the polynomial division, either bit order
    function automatic logic [15:0] step(input logic [15:0] c, input logic [7:0] d,
                                          input logic msb);
        logic [15:0] r;
        logic fb;
        r = c;
        for (int i = 0; i < 8; i++) begin
            if (msb) begin
                fb = r[15] ^ d[7 - i];
                r = {r[14:0], 1'b0} ^ (fb ? `CRC_POLY_MSB : 16'h0000);
            end else begin
                fb = r[0] ^ d[i];
                r = {1'b0, r[15:1]} ^ (fb ? `CRC_POLY_LSB : 16'h0000);
            end
        end
        return r;
    endfunction

    always_comb begin
        case (preset_sel)
            2'd0: preset = `CRC_PRESET_0;
            2'd1: preset = `CRC_PRESET_1;
            2'd2: preset = `CRC_PRESET_2;
            default: preset = `CRC_PRESET_3;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            crc_q <= `CRC_PRESET_0;
        end else if (load) begin
            crc_q <= preset;
        end else if (feed) begin
            crc_q <= step(crc_q, din, msb_first);
        end
    end
    assign crc = crc_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_preset_load: assert property (load |=> crc_q == $past(preset))
        else $error("checksum did not take preset");
    a_msb_zero: assert property (feed && !load && msb_first && crc_q == 16'h0000 && din == 8'h00
        |=> crc_q == 16'h0000)
        else $error("zero byte changed zero checksum");
endmodule
`default_nettype wire

// [rf_link_model.sv]
// far side model: decoded receive bytes in, answer bytes out
`timescale 1ns/1ps
`default_nettype none
module rf_link_model (
    input wire logic clk,           // core clock
    input wire logic slow,          // stall the answer link
    output logic rx_valid,          // byte strobe
    output logic [7:0] rx_byte,     // decoded byte
    output logic rx_end,            // end of packet
    output logic [3:0] rx_err,      // packet errors
    input wire logic tx_valid,      // answer byte valid
    input wire logic [7:0] tx_byte, // answer byte
    output logic tx_ready           // answer byte taken
);
    logic [7:0] got[$];

    // idle levels at time zero
    initial begin
        rx_valid = 1'b0;
        rx_byte = 8'h00;
        rx_end = 1'b0;
        rx_err = 4'h0;
    end

    // one packet, bytes then end pulse; released lines show inverted data, not stale data
    task automatic send(input logic [7:0] p[$], input logic [3:0] err);
        foreach (p[i]) begin
            @(posedge clk);
            rx_valid <= 1'b1;
            rx_byte <= p[i];
        end
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_byte <= ~p[p.size() - 1];
        rx_end <= 1'b1;
        rx_err <= err;
        @(posedge clk);
        rx_end <= 1'b0;
        rx_err <= ~err;
    endtask

    // encoder side: ready every cycle, or every other cycle when stalling
    always @(posedge clk) begin
        tx_ready <= slow ? ~tx_ready : 1'b1;
        if (tx_valid === 1'b1 && tx_ready === 1'b1) got.push_back(tx_byte);
    end
endmodule
`default_nettype wire

// [nfc_receive_packet_fifo_crc_bench.sv]
// self-checking bench of the packet queue block
`timescale 1ns/1ps
`default_nettype none
`include "pktq_regs.svh"
module nfc_receive_packet_fifo_crc_bench;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic slow = 1'b0;
    logic [5:0] addr = 6'h00;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata, rx_byte, tx_byte;
    logic rx_valid, rx_end, tx_valid, tx_last, tx_ready, auto_active;
    logic [3:0] rx_err;
    logic [15:0] crc;
    logic [15:0] pre[4] = '{16'h0000, 16'h6363, 16'hA671, 16'hFFFF};
    logic [15:0] codes[6] = '{16'h1234, 16'h12FF, 16'hFF34, 16'hFFFF, 16'h1256, 16'hFF35};
    logic [7:0] exp[$];
    int errors = 0;
    int cmp_count = 0;
    int last_cnt = 0;

    // 25 MHz core clock
    initial begin
        forever #20 clk = ~clk;
    end

    // short timeslots keep the polling waits small
    nfc_receive_packet_fifo_crc #(.DEPTH(64), .RESP_BYTES(20), .SLOT_CYCLES(4)) u_dut (
        .CORE_CLK(clk), .SRST(srst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .RX_VALID(rx_valid), .RX_BYTE(rx_byte), .RX_END(rx_end),
        .RX_ERR(rx_err), .TX_VALID(tx_valid), .TX_BYTE(tx_byte), .TX_LAST(tx_last),
        .TX_READY(tx_ready), .AUTO_ACTIVE(auto_active));

    rf_link_model u_link (.clk(clk), .slow(slow), .rx_valid(rx_valid), .rx_byte(rx_byte),
        .rx_end(rx_end), .rx_err(rx_err), .tx_valid(tx_valid), .tx_byte(tx_byte),
        .tx_ready(tx_ready));

    // answer bytes taken with the last marker; one per answer, none per silent poll
    always @(posedge clk) begin
        if (tx_valid === 1'b1 && tx_ready === 1'b1 && tx_last === 1'b1) last_cnt <= last_cnt + 1;
    end

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    // register write: one strobe cycle, then a quiet cycle
    task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // register read: data stands only in the cycle after the strobe
    task automatic rd_reg(input logic [5:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, e);
    endtask

    task automatic drain;
        rd_reg(`OFS_QUEUE_LEVEL, 8'(exp.size()));
        while (exp.size() > 0) rd_reg(`OFS_QUEUE_DATA, exp.pop_front());
    endtask

    // bit-serial reference of the checksum, either bit order
    function automatic logic [15:0] crc_ref(input logic [15:0] c, input logic [7:0] d,
                                            input bit msb);
        for (int i = 0; i < 8; i++) begin
            if (msb) c = (c[15] ^ d[7 - i]) ? {c[14:0], 1'b0} ^ 16'h1021 : {c[14:0], 1'b0};
            else c = (c[0] ^ d[i]) ? (c >> 1) ^ 16'h8408 : c >> 1;
        end
        return c;
    endfunction

    // answer store contents: length 19, system code 12 34 at bytes 17 and 18
    function automatic logic [7:0] resp(input int i);
        return i == 0 ? 8'h13 : i == 17 ? 8'h12 : i == 18 ? 8'h34 : 8'(8'hA0 + i);
    endfunction

    // packet whose first byte is its own length; kept ones are expected back with status
    task automatic pkt(input int len, input logic [3:0] err, input bit keep);
        logic [7:0] p[$];
        for (int k = 0; k < len; k++) p.push_back(k == 0 ? len[7:0] : 8'(len * 16 + k));
        u_link.send(p, err);
        if (keep) begin
            foreach (p[k]) exp.push_back(p[k]);
            exp.push_back({4'h0, err});
        end
    endtask

    // polling command with slot limit 3: answer must start within four slots or never
    task automatic poll(input logic [15:0] sc, input bit hit);
        logic [7:0] p[$];
        int n;
        int c0;
        p = {8'h06, 8'h00, sc[15:8], sc[7:0], 8'h00, 8'h03};
        u_link.got.delete();
        c0 = last_cnt;
        u_link.send(p, 4'h0);
        n = 0;
        #1;
        while (tx_valid !== 1'b1 && n < 40) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(8'(n < 14), 8'(hit));
        repeat (60) @(posedge clk);
        chk(8'(u_link.got.size()), hit ? 8'h13 : 8'h00);
        chk(8'(last_cnt - c0), 8'(hit));
        foreach (u_link.got[i]) chk(u_link.got[i], resp(i));
    endtask

    // watchdog well beyond the roughly one thousand cycles the tests need
    initial begin
        repeat (30000) @(posedge clk);
        errors++;
        print_verdict();
    end

    initial begin
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        // reset values and an unmapped index
        rd_reg(`OFS_GEN_MODE, 8'h00);
        rd_reg(`OFS_RX_MODE, 8'h00);
        rd_reg(`OFS_QUEUE_LEVEL, 8'h00);
        rd_reg(6'h3F, 8'h00);
        // byte order and level through the data port
        for (int i = 0; i < 3; i++) begin
            wr_reg(`OFS_QUEUE_DATA, 8'(8'h50 + i));
            exp.push_back(8'(8'h50 + i));
        end
        drain();
        // one write past the depth is dropped and flagged; only flush clears it
        for (int i = 0; i < 65; i++) wr_reg(`OFS_QUEUE_DATA, 8'(i));
        rd_reg(`OFS_QUEUE_LEVEL, 8'h40);
        rd_reg(`OFS_ERR_FLAGS, 8'h10);
        rd_reg(`OFS_QUEUE_DATA, 8'h00);
        wr_reg(`OFS_QUEUE_LEVEL, 8'h80);
        rd_reg(`OFS_QUEUE_LEVEL, 8'h00);
        rd_reg(`OFS_ERR_FLAGS, 8'h00);
        // every preset in both bit orders
        for (int p = 0; p < 8; p++) begin
            wr_reg(`OFS_GEN_MODE, {4'h0, p[2], 1'b0, p[1:0]});
            wr_reg(`OFS_CRC_DATA, 8'h31);
            crc = crc_ref(pre[p[1:0]], 8'h31, p[2]);
            rd_reg(`OFS_CRC_HI, crc[15:8]);
            rd_reg(`OFS_CRC_LO, crc[7:0]);
        end
        // length window 4..7, continuous receive, boundary lengths on both sides
        wr_reg(`OFS_LEN_LOW, 8'h01);
        wr_reg(`OFS_LEN_HIGH, 8'h02);
        wr_reg(`OFS_RX_MODE, 8'h05);
        pkt(4, 4'h0, 1);
        pkt(3, 4'h0, 0);
        pkt(8, 4'h0, 0);
        pkt(7, 4'h2, 1);
        pkt(5, 4'h1, 1);
        rd_reg(`OFS_ERR_FLAGS, 8'h01);
        drain();
        // open window, load the answer, then poll before and after the start command
        wr_reg(`OFS_LEN_HIGH, 8'h00);
        wr_reg(`OFS_LEN_LOW, 8'h00);
        wr_reg(`OFS_RESP_ADDR, 8'h00);
        for (int i = 0; i < 20; i++) wr_reg(`OFS_RESP_DATA, resp(i));
        poll(16'h1234, 1'b0);
        // without the command the polling packet is kept as plain data
        rd_reg(`OFS_QUEUE_LEVEL, 8'h07);
        wr_reg(`OFS_QUEUE_LEVEL, 8'h80);
        wr_reg(`OFS_COMMAND, {4'h0, `CMD_AUTO_ANTICOL});
        rd_reg(`OFS_COMMAND, 8'h0D);
        chk({7'h00, auto_active}, 8'h01);
        for (int k = 0; k < 6; k++) begin
            slow <= k[0];
            poll(codes[k], k < 4);
            rd_reg(`OFS_QUEUE_LEVEL, 8'h00);
        end
        // another command ends polling silently and is stored
        pkt(4, 4'h0, 1);
        rd_reg(`OFS_COMMAND, 8'h00);
        chk({7'h00, auto_active}, 8'h00);
        chk(8'(u_link.got.size()), 8'h00);
        drain();
        // single-packet mode: receiver disarms after one stored packet
        wr_reg(`OFS_RX_MODE, 8'h01);
        pkt(4, 4'h0, 1);
        pkt(4, 4'h0, 0);
        drain();
        print_verdict();
    end
endmodule
`default_nettype wire
